/* File: include/gdp_pkg.sv */
// Package for the GPIO drive and pin interrupt port
package gdp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets (port form, then pin form)
	localparam logic [7:0] OFS_DM0    = 8'h00;
	localparam logic [7:0] OFS_DM1    = 8'h04;
	localparam logic [7:0] OFS_DM2    = 8'h08;
	localparam logic [7:0] OFS_OUTVAL = 8'h0C;
	localparam logic [7:0] OFS_PSTATE = 8'h10;
	localparam logic [7:0] OFS_SLEW   = 8'h14;
	localparam logic [7:0] OFS_BYPASS = 8'h18;
	localparam logic [7:0] OFS_BIDIR  = 8'h1C;
	localparam logic [7:0] OFS_IBDIS  = 8'h20;
	localparam logic [7:0] OFS_PCTL   = 8'h24;
	localparam logic [7:0] OFS_IRISE  = 8'h28;
	localparam logic [7:0] OFS_IFALL  = 8'h2C;
	localparam logic [7:0] OFS_ISTAT  = 8'h30;
	localparam logic [7:0] OFS_REGOUT = 8'h34;
	localparam logic [7:0] OFS_INREF  = 8'h38;
	localparam logic [7:0] OFS_OESEL  = 8'h3C;
	localparam logic [7:0] OFS_PIN0   = 8'h40;
	localparam logic [7:0] OFS_PIN7   = 8'h5C;

	////////////////////////////////////////////////////////////////////////
	// Pin form field positions
	localparam int unsigned PF_DM0 = 0;
	localparam int unsigned PF_DM1 = 1;
	localparam int unsigned PF_DM2 = 2;
	localparam int unsigned PF_OUT = 3;
	localparam int unsigned PF_PIN_STATE = 4;
	localparam int unsigned PF_SLW = 5;
	localparam int unsigned PF_BYP = 6;
	localparam int unsigned PF_BIE = 7;

	// Port control field: threshold select
	localparam int unsigned PCTL_LVTTL = 0;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [31:0] RST_OESEL = 32'h0000_0000;

	// Drive mode codes
	localparam logic [2:0] DM_HIZ_ANA = 3'h0;
	localparam logic [2:0] DM_HIZ_DIG = 3'h1;
	localparam logic [2:0] DM_RES_UP  = 3'h2;
	localparam logic [2:0] DM_RES_DN  = 3'h3;
	localparam logic [2:0] DM_OD_LOW  = 3'h4;
	localparam logic [2:0] DM_OD_HIGH = 3'h5;
	localparam logic [2:0] DM_STRONG  = 3'h6;
	localparam logic [2:0] DM_RES_UD  = 3'h7;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Pad control carrier, one bit per pin in each field
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
		logic [7:0] res_oe;
		logic [7:0] slow;
		logic [7:0] ibuf_en;
		logic [7:0] reg_hi;
	} gdp_pad_t;

	// Whole state of the port
	typedef struct packed {
		logic [7:0]  dm0;
		logic [7:0]  dm1;
		logic [7:0]  dm2;
		logic [7:0]  outval;
		logic [7:0]  slew;
		logic [7:0]  bypass;
		logic [7:0]  bidir;
		logic [7:0]  ibdis;
		logic        lvttl;
		logic [7:0]  irise;
		logic [7:0]  ifall;
		logic [7:0]  istat;
		logic [7:0]  regout;
		logic [7:0]  inref;
		logic [31:0] oesel;
		logic [7:0]  s1;
		logic [7:0]  s2;
		logic [7:0]  s3;
		logic [7:0]  flt;
		logic [7:0]  din;
		gdp_pad_t    pad;
		logic        irq;
		logic        aw_rdy;
		logic        aw_full;
		logic [7:0]  awaddr;
		logic        w_rdy;
		logic        w_full;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        ar_rdy;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} gdp_state_t;

endpackage

/* File: src/gdp_port.sv */
// GPIO port: drive modes, pin views, bidirectional control, edge interrupts
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Mode 000: no drive, input buffer off
// - Mode 001: high-Z, input buffer on
// - Modes 010/011: resistive/strong pull combinations
// - Modes 100/101: open drain low/high
// - Mode 110: strong high and low
// - Mode 111: resistive high and low
// - Analog mode gives no digital input
// - Regulated output forbids resistive drive
// - Port form: one bit per pin
// - Pin form gathers eight bits, shared state
// - Bidirectional: aux enable selects drive or input
// - Sixteen aux enables routable to pins
// - Slew select only in strong/open drain
// - Per pin rising/falling/both/no interrupt
// - Edge sets status bit, raises request
// - Eight pins share one port request
// - Edge detection only, no levels
// - Port threshold select CMOS or LVTTL
// - Per pin input buffer disable, any mode
// - Per pin regulated high output select, all eight pins
// - Pair shares input reference select
// - Pin state read separate from output data
// - Drive follows data or bypass signal
// - Reset returns pins to analog high-Z
module gdp_port
	import gdp_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        NRST,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output      logic        AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output      logic        WREADY,
	// AXI4-Lite write response
	output      logic        BVALID,
	input  wire logic        BREADY,
	output      logic [1:0]  BRESP,
	// AXI4-Lite read
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output      logic        ARREADY,
	output      logic        RVALID,
	input  wire logic        RREADY,
	output      logic [31:0] RDATA,
	output      logic [1:0]  RRESP,
	// Digital array side
	input  wire logic [7:0]  DSI_OUT,
	input  wire logic [15:0] AUX_OE,
	output      logic [7:0]  DSI_IN,
	output      logic        PORT_IRQ,
	// Pads
	input  wire logic [7:0]  PIN_IN,
	output      gdp_pad_t    PAD,
	output      logic        LVTTL_SEL,
	output      logic [7:0]  INREF_SEL
);

	////////////////////////////////////////////////////////////////////////
	// Bus timing
	// Address and data each fill a one-deep slot, in either order
	// The register changes at the edge after both slots are full
	// The write answer stands until taken; a new write waits for it
	// Read data is latched at the edge the read address is taken
	// The read address channel stays closed while an answer stands
	// Unmapped offsets answer with an error and change nothing
	// Byte lane 0 carries every 8-bit register; the selector word uses all four
	// Upper data bits of an 8-bit register read as zero
	// The two low address bits are ignored on both channels
	// Readies are low in reset and rise at the first edge after it
	// Nothing here waits on a pin, so the bus answer time is fixed

	////////////////////////////////////////////////////////////////////////
	// State and next state
	gdp_state_t q;
	gdp_state_t n;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] clr;
	logic [2:0] mode;
	logic       dat;
	logic       wr_fire;
	logic [2:0] idx;
	logic [7:0] wb;
	logic [32:0] rd;

	////////////////////////////////////////////////////////////////////////
	// Pin form offsets sit above the port form ones, one word per pin
	// Pin form address check, used by read and write decode
	function automatic logic is_pin_form(input logic [7:0] a);
		return (a >= OFS_PIN0) && (a <= OFS_PIN7);
	endfunction

	// Read decode: bit 32 is the hit flag, low word the data
	// Pin form reads gather the eight per-pin bits; the pin state bit is
	// the masked, synchronised level, never the written output value
	function automatic logic [32:0] rd_word(input gdp_state_t s, input logic [7:0] a);
		logic [2:0] p;
		logic [7:0] v;
		p = a[4:2];
		v = 8'h00;
		if (is_pin_form(a)) begin
			v[PF_DM0] = s.dm0[p];
			v[PF_DM1] = s.dm1[p];
			v[PF_DM2] = s.dm2[p];
			v[PF_OUT] = s.outval[p];
			v[PF_PIN_STATE] = s.din[p];
			v[PF_SLW] = s.slew[p];
			v[PF_BYP] = s.bypass[p];
			v[PF_BIE] = s.bidir[p];
			return {1'b1, 24'h00_0000, v};
		end
		case (a)
			OFS_DM0:    return {1'b1, 24'h00_0000, s.dm0};
			OFS_DM1:    return {1'b1, 24'h00_0000, s.dm1};
			OFS_DM2:    return {1'b1, 24'h00_0000, s.dm2};
			OFS_OUTVAL: return {1'b1, 24'h00_0000, s.outval};
			OFS_PSTATE: return {1'b1, 24'h00_0000, s.din};
			OFS_SLEW:   return {1'b1, 24'h00_0000, s.slew};
			OFS_BYPASS: return {1'b1, 24'h00_0000, s.bypass};
			OFS_BIDIR:  return {1'b1, 24'h00_0000, s.bidir};
			OFS_IBDIS:  return {1'b1, 24'h00_0000, s.ibdis};
			OFS_PCTL:   return {1'b1, 31'h0000_0000, s.lvttl};
			OFS_IRISE:  return {1'b1, 24'h00_0000, s.irise};
			OFS_IFALL:  return {1'b1, 24'h00_0000, s.ifall};
			OFS_ISTAT:  return {1'b1, 24'h00_0000, s.istat};
			OFS_REGOUT: return {1'b1, 24'h00_0000, s.regout};
			OFS_INREF:  return {1'b1, 24'h00_0000, s.inref};
			OFS_OESEL:  return {1'b1, s.oesel};
			default:    return {1'b0, 32'h0000_0000};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next state logic
	always_comb begin
		n       = q;
		rise    = 8'h00;
		fall    = 8'h00;
		clr     = 8'h00;
		mode    = DM_HIZ_ANA;
		dat     = 1'b0;
		idx     = q.awaddr[4:2];
		wb      = q.wdata[7:0];
		rd      = {1'b0, 32'h0000_0000};
		wr_fire = q.aw_full && q.w_full && !q.bvalid;

		// Three stage pin synchroniser; a level counts once stages agree
		// The first stage may go metastable; only the second stage reads it
		// A level that flips between the second and third stage is not taken
		// Pin changes reach the status bits five edges after the pad
		n.s1 = PIN_IN;
		n.s2 = q.s1;
		n.s3 = q.s2;
		for (int i = 0; i < 8; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				n.flt[i] = q.s3[i];
			end
		end

		// A buffer switched off on a high pin looks like a falling edge;
		// set the edge enables only after the buffer has settled
		// masked input value from the live buffer enable
		n.din = q.flt & q.pad.ibuf_en;

		// Edges use the same masked level that the read path shows
		// Setting both enables of a pin gives interrupts on both edges
		// per pin edge selection
		rise = n.din & ~q.din & q.irise;
		fall = ~n.din & q.din & q.ifall;

		// Write address and data channels, either order
		// Each slot closes once full and reopens at the write edge,
		// so a master that keeps valid high is not taken twice
		if (q.aw_rdy && AWVALID) begin
			n.awaddr  = {AWADDR[7:2], 2'b00};
			n.aw_full = 1'b1;
		end
		if (q.w_rdy && WVALID) begin
			n.wdata  = WDATA;
			n.wstrb  = WSTRB;
			n.w_full = 1'b1;
		end

		// A write to the pin state register is accepted but has no effect
		// Status bits are write one to clear through byte lane 0
		// Register write when both halves are held
		if (wr_fire) begin
			n.aw_full = 1'b0;
			n.w_full  = 1'b0;
			n.bvalid  = 1'b1;
			n.bresp   = RESP_OKAY;
			if (is_pin_form(q.awaddr)) begin
				// pin form write updates shared state
				if (q.wstrb[0]) begin
					n.dm0[idx]    = wb[PF_DM0];
					n.dm1[idx]    = wb[PF_DM1];
					n.dm2[idx]    = wb[PF_DM2];
					n.outval[idx] = wb[PF_OUT];
					n.slew[idx]   = wb[PF_SLW];
					n.bypass[idx] = wb[PF_BYP];
					n.bidir[idx]  = wb[PF_BIE];
				end
			end else if (q.wstrb[0] || q.awaddr == OFS_OESEL) begin
				// port form: each bit is one pin
				case (q.awaddr)
					OFS_DM0:    n.dm0    = wb;
					OFS_DM1:    n.dm1    = wb;
					OFS_DM2:    n.dm2    = wb;
					OFS_OUTVAL: n.outval = wb;
					OFS_PSTATE: n.bresp  = RESP_OKAY;
					OFS_SLEW:   n.slew   = wb;
					OFS_BYPASS: n.bypass = wb;
					OFS_BIDIR:  n.bidir  = wb;
					OFS_IBDIS:  n.ibdis  = wb;
					OFS_PCTL:   n.lvttl  = wb[PCTL_LVTTL];
					OFS_IRISE:  n.irise  = wb;
					OFS_IFALL:  n.ifall  = wb;
					OFS_ISTAT:  clr      = wb;
					OFS_REGOUT: n.regout = wb;
					// one two-bit threshold code per pin pair
					OFS_INREF:  n.inref  = wb;
					OFS_OESEL: begin
						// Four bits per pin pick one of the sixteen aux enables
						// aux enable selectors, byte lanes
						for (int b = 0; b < 4; b++) begin
							if (q.wstrb[b]) begin
								n.oesel[b*8 +: 8] = q.wdata[b*8 +: 8];
							end
						end
					end
					default:    n.bresp  = RESP_SLVERR;
				endcase
			end else if (rd_word(q, q.awaddr) == {1'b0, 32'h0000_0000}) begin
				n.bresp = RESP_SLVERR;
			end
		end
		if (q.bvalid && BREADY) begin
			n.bvalid = 1'b0;
		end
		n.aw_rdy = !n.aw_full;
		n.w_rdy  = !n.w_full;

		// Reads see the state before this edge, so a write and a read
		// finishing in the same cycle return the old value
		// Read channel: answer one edge after acceptance
		if (q.ar_rdy && ARVALID) begin
			rd      = rd_word(q, {ARADDR[7:2], 2'b00});
			n.rvalid = 1'b1;
			n.rdata  = rd[31:0];
			n.rresp  = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end
		if (q.rvalid && RREADY) begin
			n.rvalid = 1'b0;
		end
		n.ar_rdy = !n.rvalid;

		// An event in the same cycle as its clear leaves the bit set,
		// so an edge that lands during the clear is never lost
		// edge sets the status bit
		// set wins over a clear in the same cycle
		n.istat = (q.istat & ~clr) | rise | fall;
		// one request for all eight pins
		// request held while any bit is set
		n.irq = |n.istat;

		// Pad drive resolution per pin
		// Each pin first works out its effective mode: the configured one,
		// or digital input when a bidirectional pin's enable is low
		// Data comes from the output value or from the bypass input
		// oe drives o strongly, res_oe drives o through the resistor
		// The two legs are never on together for one pin
		for (int i = 0; i < 8; i++) begin
			mode = {q.dm2[i], q.dm1[i], q.dm0[i]};
			// data from output value or bypass signal
			dat = q.bypass[i] ? DSI_OUT[i] : q.outval[i];
			// aux enable low turns a bidir pin into an input
			// each pin picks one of sixteen enables
			if (q.bidir[i] && !AUX_OE[q.oesel[i*4 +: 4]]) begin
				mode = DM_HIZ_DIG;
			end
			n.pad.o[i]      = dat;
			n.pad.oe[i]     = 1'b0;
			n.pad.res_oe[i] = 1'b0;
			case (mode)
				DM_HIZ_ANA: n.pad.oe[i] = 1'b0;
				DM_HIZ_DIG: n.pad.oe[i] = 1'b0;
				DM_RES_UP: begin
					n.pad.oe[i]     = !dat;
					n.pad.res_oe[i] = dat;
				end
				DM_RES_DN: begin
					n.pad.oe[i]     = dat;
					n.pad.res_oe[i] = !dat;
				end
				DM_OD_LOW:  n.pad.oe[i] = !dat;
				DM_OD_HIGH: n.pad.oe[i] = dat;
				DM_STRONG:  n.pad.oe[i] = 1'b1;
				DM_RES_UD:  n.pad.res_oe[i] = 1'b1;
				default:    n.pad.oe[i] = 1'b0;
			endcase
			// Every pin of this port can take the regulated high level
			// regulated output suppresses resistive legs
			if (q.regout[i]) begin
				n.pad.res_oe[i] = 1'b0;
			end
			n.pad.reg_hi[i] = q.regout[i];
			// Resistive modes always run at the default edge rate
			// slow edges only in strong and open drain modes
			n.pad.slow[i] = q.slew[i] &&
				(mode == DM_OD_LOW || mode == DM_OD_HIGH || mode == DM_STRONG);
			// A bidirectional pin turned to input keeps its buffer on
			// analog mode turns the buffer off
			n.pad.ibuf_en[i] = (mode != DM_HIZ_ANA) && !q.ibdis[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	// Reset is synchronous; every pin returns to analog high-Z and all
	// readies are low until the first edge with reset released
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			q        <= '0;
			q.dm0    <= RST_BYTE;
			q.dm1    <= RST_BYTE;
			q.dm2    <= RST_BYTE;
			q.oesel  <= RST_OESEL;
		end else begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	// No logic sits after the register, so pad timing does not depend
	// on the bus or on the pins
	assign AWREADY   = q.aw_rdy;
	assign WREADY    = q.w_rdy;
	assign BVALID    = q.bvalid;
	assign BRESP     = q.bresp;
	assign ARREADY   = q.ar_rdy;
	assign RVALID    = q.rvalid;
	assign RDATA     = q.rdata;
	assign RRESP     = q.rresp;
	assign DSI_IN    = q.din;
	assign PORT_IRQ  = q.irq;
	assign PAD       = q.pad;
	assign LVTTL_SEL = q.lvttl;
	assign INREF_SEL = q.inref;

endmodule // gdp_port

/* File: tb/gdp_port_sva.sv */
// Checker for the GPIO port's bus answers and pad legs
`timescale 1ns/1ps
module gdp_port_sva
	import gdp_pkg::*;
(
	// Clock and reset
	input wire logic        CLK,
	input wire logic        NRST,
	// Bus handshakes
	input wire logic        AWVALID,
	input wire logic        AWREADY,
	input wire logic        WVALID,
	input wire logic        WREADY,
	input wire logic        BVALID,
	input wire logic [7:0]  ARADDR,
	input wire logic        ARVALID,
	input wire logic        ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0]  RRESP,
	// Pin side
	input wire logic [7:0]  DSI_IN,
	input wire logic        PORT_IRQ,
	input wire gdp_pad_t    PAD
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	////////////////////////////////////////////////////////////////////////
	// reset clears outputs
	property p_reset;
		disable iff (1'b0) !NRST |=> PAD == '0 && DSI_IN == 8'h00 && !PORT_IRQ;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
	property p_ibuf;
		(DSI_IN & ~(PAD.ibuf_en | $past(PAD.ibuf_en) | $past(PAD.ibuf_en, 2))) == 8'h00;
	endproperty
	a_ibuf: assert property (p_ibuf) else $error("input seen with buffer off");
	property p_legs;
		(PAD.oe & PAD.res_oe) == 8'h00;
	endproperty
	a_legs: assert property (p_legs) else $error("strong and resistive legs together");
	property p_slew;
		(PAD.slow & PAD.res_oe) == 8'h00;
	endproperty
	a_slew: assert property (p_slew) else $error("slow slew on resistive leg");
	property p_reghi;
		(PAD.reg_hi & PAD.res_oe) == 8'h00;
	endproperty
	a_reghi: assert property (p_reghi) else $error("resistive leg in regulated output");
	property p_irq_hold;
		$fell(PORT_IRQ) |-> BVALID;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("request dropped without a write");

	////////////////////////////////////////////////////////////////////////
	// Write answer follows the taken address and data
	sequence s_wr_take;
		AWVALID && AWREADY && WVALID && WREADY;
	endsequence
	property p_wr_resp;
		s_wr_take |-> ##[1:2] BVALID;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");
	// Unmapped read gives an error and zero data
	property p_rd_err;
		ARVALID && ARREADY && ARADDR[7:2] > OFS_PIN7[7:2] |=> RRESP == RESP_SLVERR && RDATA == 32'h0000_0000;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
endmodule // gdp_port_sva

bind gdp_port gdp_port_sva u_sva (.CLK(CLK), .NRST(NRST), .AWVALID(AWVALID), .AWREADY(AWREADY),
	.WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .ARADDR(ARADDR), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .DSI_IN(DSI_IN), .PORT_IRQ(PORT_IRQ), .PAD(PAD));

/* File: tb/gdp_pins_model.sv */
// Model of the board circuitry at the port's pins
`timescale 1ns/1ps
module gdp_pins_model
	import gdp_pkg::*;
(
	// Pad controls from the port
	input  wire gdp_pad_t   pad,
	// Board side drive
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	// Levels seen at the pads
	output      logic [7:0] pin_in
);
	// Strong leg wins, then the board, then the resistive leg; else a pull-down
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = pad.oe[i] ? pad.o[i] : ext_en[i] ? ext_val[i] : pad.res_oe[i] & pad.o[i];
		end
	end
endmodule // gdp_pins_model

/* File: tb/test_gdp_port.sv */
// Testbench for the GPIO drive and pin interrupt port
`timescale 1ns/1ps
module test_gdp_port import gdp_pkg::*;;
	// Stimulus and observation
	logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
	logic        awready, wready, arready, irq, lvttl;
	logic [7:0]  awaddr, araddr, dsi_out, dsi_in, ext_en, ext_val, pins, inref;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, lg;
	logic [15:0] aux_oe;
	gdp_pad_t    pad;
	int          miscompares, comparisons, m, d;

	gdp_port u_dut (.CLK(clk), .NRST(nrst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
		.WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata),
		.RRESP(rresp), .DSI_OUT(dsi_out), .AUX_OE(aux_oe), .DSI_IN(dsi_in), .PORT_IRQ(irq), .PIN_IN(pins),
		.PAD(pad), .LVTTL_SEL(lvttl), .INREF_SEL(inref));
	gdp_pins_model u_pins (.pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pins));

	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	// Verdict and compare
	task automatic give_verdict();
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// A spent wait bound ends the run
	task automatic guard(input int n);
		if (n >= 60) begin
			miscompares++;
			give_verdict();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Bus write: each channel dropped when taken, response awaited
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid && n < 60);
		guard(n);
		chk("bresp", (a[7:2] > OFS_PIN7[7:2]) ? RESP_SLVERR : RESP_OKAY, bresp);
	endtask
	// Bus read with data and response compare
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid && n < 60);
		guard(n);
		chk("rdata", e, rdata);
		chk("rresp", r, rresp);
	endtask
	// Expected legs {strong, resistive} per mode and data
	function automatic logic [1:0] legs(input int m, input int d);
		case (m)
			2, 3: return (d == m - 2) ? 2'b10 : 2'b01;
			4, 5: return (d == m - 4) ? 2'b10 : 2'b00;
			6: return 2'b10;
			7: return 2'b01;
			default: return 2'b00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{nrst, awvalid, wvalid, arvalid, awaddr, araddr, wdata, dsi_out, aux_oe, ext_en, ext_val} = '0;
		{bready, rready, wstrb} = 6'h3F;
		miscompares = 0;
		comparisons = 0;
		tick(16);
		nrst <= 1'b1;
		tick(3);
		chk("pad", 0, pad);
		for (m = 0; m < 96; m += 4) rd(8'(m), 0, RESP_OKAY);
		wr(OFS_PIN0 + 8'h0C, 32'h0000_000E);
		rd(OFS_DM2, 32'h0000_0008, RESP_OKAY);
		rd(OFS_OUTVAL, 32'h0000_0008, RESP_OKAY);
		wr(OFS_DM0, 32'h0000_0008);
		tick(8);
		rd(OFS_PIN0 + 8'h0C, 32'h0000_001F, RESP_OKAY);
		wr(OFS_SLEW, 32'h0000_00FF);
		for (m = 0; m < 8; m++) for (d = 0; d < 2; d++) begin
			wr(OFS_DM0, 32'({8{m[0]}}));
			wr(OFS_DM1, 32'({8{m[1]}}));
			wr(OFS_DM2, 32'({8{m[2]}}));
			wr(OFS_OUTVAL, 32'({8{d[0]}}));
			tick(2);
			lg = legs(m, d);
			chk("oe", {8{lg[1]}}, pad.oe);
			chk("res_oe", {8{lg[0]}}, pad.res_oe);
			chk("ibuf", (m == 0) ? 8'h00 : 8'hFF, pad.ibuf_en);
			if (lg != 2'b00) chk("o", {8{d[0]}}, pad.o);
			if (m >= 2) chk("slow", (m >= 4 && m <= 6) ? 8'hFF : 8'h00, pad.slow);
		end
		ext_en <= 8'hFF;
		ext_val <= 8'hA5;
		wr(OFS_DM1, 32'h0000_0000);
		wr(OFS_DM2, 32'h0000_0000);
		wr(OFS_OUTVAL, 32'h0000_005A);
		wr(OFS_PSTATE, 32'h0000_00FF);
		tick(8);
		rd(OFS_PSTATE, 32'h0000_00A5, RESP_OKAY);
		wr(OFS_IBDIS, 32'h0000_000F);
		tick(8);
		chk("dsi_in", 8'hA0, dsi_in);
		wr(OFS_DM0, 32'h0000_0000);
		tick(8);
		chk("dsi_in", 8'h00, dsi_in);
		ext_val <= 8'h00;
		wr(OFS_IBDIS, 32'h0000_0000);
		wr(OFS_DM0, 32'h0000_00FF);
		wr(OFS_IRISE, 32'h0000_0005);
		wr(OFS_IFALL, 32'h0000_0006);
		ext_val <= 8'h0F;
		tick(20);
		rd(OFS_ISTAT, 32'h0000_0005, RESP_OKAY);
		chk("irq", 1, irq);
		wr(OFS_ISTAT, 32'h0000_0005);
		rd(OFS_ISTAT, 32'h0000_0000, RESP_OKAY);
		chk("irq", 0, irq);
		ext_val <= 8'h00;
		tick(8);
		rd(OFS_ISTAT, 32'h0000_0006, RESP_OKAY);
		wr(OFS_ISTAT, 32'h0000_0005);
		rd(OFS_ISTAT, 32'h0000_0002, RESP_OKAY);
		chk("irq", 1, irq);
		wr(OFS_ISTAT, 32'h0000_0002);
		tick(3);
		chk("irq", 0, irq);
		ext_en <= 8'h00;
		wr(OFS_DM1, 32'h0000_00FF);
		wr(OFS_DM2, 32'h0000_00FF);
		wr(OFS_DM0, 32'h0000_0000);
		wr(OFS_OESEL, 32'hFEDC_BA98);
		wr(OFS_BIDIR, 32'h0000_00FF);
		aux_oe <= 16'h0500;
		tick(3);
		chk("oe", 8'h05, pad.oe);
		aux_oe <= 16'hFF00;
		tick(3);
		chk("oe", 8'hFF, pad.oe);
		wr(OFS_BIDIR, 32'h0000_0000);
		dsi_out <= 8'h3C;
		wr(OFS_BYPASS, 32'h0000_00FF);
		tick(3);
		chk("o", 8'h3C, pad.o);
		wr(OFS_REGOUT, 32'h0000_00FF);
		wr(OFS_DM0, 32'h0000_00FF);
		wr(OFS_PCTL, 32'h0000_0001);
		wr(OFS_INREF, 32'h0000_00E4);
		tick(3);
		chk("reg_hi", 8'hFF, pad.reg_hi);
		chk("res_oe", 8'h00, pad.res_oe);
		chk("lvttl", 1, lvttl);
		chk("inref", 8'hE4, inref);
		nrst <= 1'b0;
		tick(2);
		nrst <= 1'b1;
		tick(3);
		rd(OFS_DM0, 0, RESP_OKAY);
		wr(8'h60, 32'h0000_00FF);
		rd(8'h60, 0, RESP_SLVERR);
		give_verdict();
	end
endmodule // test_gdp_port
